//--- ddr2_cmd_pkg.sv
// Constants for the DDR2 command and address front end
`default_nettype none
package ddr2_cmd_pkg;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int COL_W = 9;
  localparam int AP_BIT = 10;
  localparam int BURST_SHORT = 4;
  localparam int BURST_LONG = 8;
  // Mode register bit positions used by this block
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int EMR_ODT_LO_BIT = 2;
  localparam int EMR_ODT_HI_BIT = 6;
  localparam logic [2:0] MR_BL_FOUR = 3'h2;
  localparam logic [2:0] MR_BL_EIGHT = 3'h3;
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0002;
  localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000;
  localparam logic [1:0] MRS_BASE = 2'h0;
  localparam logic [1:0] MRS_EXT1 = 2'h1;
  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  typedef enum logic [2:0] {PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF} pwr_e;
endpackage
`default_nettype wire

//--- ddr2_sync2.sv
// Two flip-flop synchroniser for one level
`default_nettype none
module ddr2_sync2 (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- ddr2_burst_ctr.sv
// Burst beat counter with sequential or interleaved column order
`default_nettype none
module ddr2_burst_ctr import ddr2_cmd_pkg::*; #(
  parameter int COLS = COL_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic step_i,
  input wire logic [COLS-1:0] col_i,
  input wire logic long_i,
  input wire logic interleave_i,
  output logic busy_o,
  output logic last_o,
  output logic [COLS-1:0] col_o
);
  logic [2:0] beat_q;
  logic [COLS-1:0] base_q;
  logic [2:0] off;
  logic [2:0] max;
  logic [2:0] low;
  assign max = long_i ? 3'(BURST_LONG - 1) : 3'(BURST_SHORT - 1);
  // Interleave xors the beat into the start column, sequential wraps inside the burst
  assign off = interleave_i ? (base_q[2:0] ^ beat_q) : (base_q[2:0] + beat_q);
  assign low = long_i ? off : {base_q[2], off[1:0]};
  assign col_o = {base_q[COLS-1:3], low};
  assign last_o = busy_o && (beat_q == max);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      beat_q <= 3'h0;
      base_q <= '0;
      busy_o <= 1'b0;
    end else if (start_i) begin
      beat_q <= 3'h0;
      base_q <= col_i;
      busy_o <= 1'b1;
    end else if (busy_o && step_i) begin
      beat_q <= beat_q + 3'h1;
      if (beat_q == max) begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- ddr2_cmd_front.sv
// DDR2 command, address and control decode front end
`default_nettype none
module ddr2_cmd_front import ddr2_cmd_pkg::*; #(
  parameter int BANKS = 4,
  parameter int DQ_W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ck_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [BANK_W-1:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic odt_i,
  input wire logic [DQ_W-1:0] dq_i,
  input wire logic lower_byte_write_mask_i,
  input wire logic upper_byte_write_mask_i,
  input wire logic lower_byte_strobe_i,
  input wire logic upper_byte_strobe_i,
  input wire logic [DQ_W-1:0] rd_data_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_n_o,
  output logic lower_byte_strobe_o,
  output logic upper_byte_strobe_o,
  output logic strobe_oe_n_o,
  output logic [BANK_W-1:0] act_bank_o,
  output logic [ADDR_W-1:0] act_row_o,
  output logic act_pulse_o,
  output logic [BANK_W-1:0] rw_bank_o,
  output logic [COL_W-1:0] rw_col_o,
  output logic rd_pulse_o,
  output logic wr_pulse_o,
  output logic auto_pre_o,
  output logic pre_pulse_o,
  output logic [BANKS-1:0] pre_banks_o,
  output logic ref_pulse_o,
  output logic [BANKS-1:0] open_banks_o,
  output logic [ADDR_W-1:0] mode_reg_o,
  output logic [ADDR_W-1:0] ext_mode_reg_o,
  output logic [COL_W-1:0] beat_col_o,
  output logic rd_beat_o,
  output logic [DQ_W-1:0] wr_data_o,
  output logic [1:0] wr_byte_en_o,
  output logic wr_beat_o,
  output logic odt_on_o,
  output logic clocks_on_o,
  output logic cmd_buf_on_o,
  output logic odt_buf_on_o,
  output logic [2:0] pwr_state_o
);
  logic ck_s;
  logic cke_s;
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic odt_s;
  logic lstb_s;
  logic ustb_s;
  logic lm_s;
  logic um_s;
  logic ck_q;
  logic lstb_q;
  logic ustb_q;
  // Upper byte lane is captured at its own strobe edge
  logic [DQ_W/2-1:0] upper_byte_q;
  logic upper_en_q;
  logic [BANK_W-1:0] ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DQ_W-1:0] dq_s;
  pwr_e pwr_q;
  logic cke_q;
  logic rd_busy_q;
  logic [BANKS-1:0] open_q;
  logic [DQ_W-1:0] rd_hold_q;

  // Every pin is brought into clk_i before any decode looks at it
  localparam int NSYNC = 11 + BANK_W + ADDR_W + DQ_W;
  logic [NSYNC-1:0] pin_raw, pin_s;
  assign pin_raw = {ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i,
                    lower_byte_strobe_i, upper_byte_strobe_i,
                    lower_byte_write_mask_i, upper_byte_write_mask_i, ba_i, addr_i, dq_i};
  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    ddr2_sync2 u_sync (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(pin_raw[g]), .q_o(pin_s[g]));
  end
  assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, lstb_s, ustb_s,
          lm_s, um_s, ba_s, addr_s, dq_s} = pin_s;

  // Clock edges found by sampling the link clock
  wire ck_rise = ck_s && !ck_q;
  wire ck_fall = !ck_s && ck_q;
  wire ck_cross = ck_rise || ck_fall;
  wire stb_edge = lstb_s ^ lstb_q;
  wire ustb_edge = ustb_s ^ ustb_q;
  // Upper byte rides its own strobe; held until the lower strobe paces the beat
  wire [DQ_W/2-1:0] upper_data = ustb_edge ? dq_s[DQ_W-1 -: DQ_W/2] : upper_byte_q;
  wire upper_en = ustb_edge ? !um_s : upper_en_q;

  wire powered = (pwr_q == PWR_ON);
  wire all_idle = (open_q == '0);
  // Command accepted only at a rising edge with CKE held and chip selected
  wire [2:0] cmd = {ras_n_s, cas_n_s, we_n_s};
  wire cmd_take = ck_rise && powered && cke_s && cke_q && !cs_n_s;
  wire is_act = cmd_take && (cmd == CMD_ACT);
  wire is_rd = cmd_take && (cmd == CMD_RD);
  wire is_wr = cmd_take && (cmd == CMD_WR);
  wire is_pre = cmd_take && (cmd == CMD_PRE);
  wire is_mrs = cmd_take && (cmd == CMD_MRS);
  wire is_ref = cmd_take && (cmd == CMD_REF);
  // Refresh with CKE falling and every bank closed is self refresh entry
  wire self_entry = ck_rise && powered && cke_q && !cke_s && !cs_n_s &&
                    (cmd == CMD_REF) && all_idle;
  wire pd_entry = ck_rise && powered && cke_q && !cke_s && !self_entry;
  wire pd_exit = ck_rise && cke_s && (pwr_q == PWR_PRE_PD || pwr_q == PWR_ACT_PD);
  // Self refresh leaves on CKE alone; the link clock may be stopped
  wire self_exit = (pwr_q == PWR_SELF) && cke_s;

  wire [BANKS-1:0] bank_hot = BANKS'(1) << ba_s;
  wire [BANKS-1:0] pre_set = addr_s[AP_BIT] ? {BANKS{1'b1}} : bank_hot;
  wire long_burst = (mode_reg_o[MR_BL_LSB +: 3] == MR_BL_EIGHT);
  wire interleave = mode_reg_o[MR_BT_BIT];
  wire odt_enabled = ext_mode_reg_o[EMR_ODT_LO_BIT] || ext_mode_reg_o[EMR_ODT_HI_BIT];
  logic burst_busy, burst_last;

  ddr2_burst_ctr #(.COLS(COL_W)) u_burst (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(is_rd || is_wr),
    .step_i(rd_busy_q ? ck_cross : stb_edge),
    .col_i(addr_s[COL_W-1:0]),
    .long_i(long_burst),
    .interleave_i(interleave),
    .busy_o(burst_busy),
    .last_o(burst_last),
    .col_o(beat_col_o)
  );

  wire rd_step = rd_busy_q && burst_busy && ck_cross;
  wire wr_step = !rd_busy_q && burst_busy && stb_edge && powered;
  assign clocks_on_o = powered;
  assign cmd_buf_on_o = powered;
  assign odt_buf_on_o = (pwr_q != PWR_SELF);
  assign pwr_state_o = pwr_q;
  assign open_banks_o = open_q;
  assign rd_beat_o = rd_step;
  // Device owns the strobe and data only while a read burst runs
  assign dq_oe_n_o = !(rd_busy_q && burst_busy && powered);
  assign strobe_oe_n_o = dq_oe_n_o;
  assign lower_byte_strobe_o = ck_q;
  assign upper_byte_strobe_o = ck_q;
  assign dq_o = rd_hold_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ck_q <= 1'b0;
      lstb_q <= 1'b0;
      ustb_q <= 1'b0;
      upper_byte_q <= '0;
      upper_en_q <= 1'b0;
      cke_q <= 1'b0;
    end else begin
      ck_q <= ck_s;
      lstb_q <= lstb_s;
      ustb_q <= ustb_s;
      // CKE is judged against its level at the previous link rising edge,
      // since the pin settles long before the edge that registers it
      if (ck_rise) begin
        cke_q <= cke_s;
      end
      if (ustb_edge) begin
        upper_byte_q <= dq_s[DQ_W-1 -: DQ_W/2];
        upper_en_q <= !um_s;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_q <= PWR_ON;
    end else begin
      case (pwr_q)
        PWR_ON: begin
          if (self_entry) begin
            pwr_q <= PWR_SELF;
          end else if (pd_entry) begin
            pwr_q <= all_idle ? PWR_PRE_PD : PWR_ACT_PD;
          end
        end
        PWR_PRE_PD, PWR_ACT_PD: begin
          if (pd_exit) begin
            pwr_q <= PWR_ON;
          end
        end
        PWR_SELF: begin
          if (self_exit) begin
            pwr_q <= PWR_ON;
          end
        end
        default: pwr_q <= PWR_ON;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      open_q <= '0;
      act_bank_o <= '0;
      act_row_o <= '0;
      rw_bank_o <= '0;
      rw_col_o <= '0;
      auto_pre_o <= 1'b0;
      pre_banks_o <= '0;
      mode_reg_o <= MR_RESET;
      ext_mode_reg_o <= EMR_RESET;
      rd_busy_q <= 1'b0;
    end else begin
      if (is_act) begin
        act_bank_o <= ba_s;
        act_row_o <= addr_s;
        open_q <= open_q | bank_hot;
      end else if (is_pre) begin
        pre_banks_o <= pre_set;
        open_q <= open_q & ~pre_set;
      end else if (burst_last && auto_pre_o && (rd_step || wr_step)) begin
        open_q <= open_q & ~(BANKS'(1) << rw_bank_o);
      end
      if (is_rd || is_wr) begin
        rw_bank_o <= ba_s;
        rw_col_o <= addr_s[COL_W-1:0];
        auto_pre_o <= addr_s[AP_BIT];
        rd_busy_q <= is_rd;
      end
      if (is_mrs && ba_s == MRS_BASE) begin
        mode_reg_o <= addr_s;
      end
      if (is_mrs && ba_s == MRS_EXT1) begin
        ext_mode_reg_o <= addr_s;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_pulse_o <= 1'b0;
      rd_pulse_o <= 1'b0;
      wr_pulse_o <= 1'b0;
      pre_pulse_o <= 1'b0;
      ref_pulse_o <= 1'b0;
      odt_on_o <= 1'b0;
      rd_hold_q <= '0;
      wr_data_o <= '0;
      wr_byte_en_o <= 2'h0;
      wr_beat_o <= 1'b0;
    end else begin
      act_pulse_o <= is_act;
      rd_pulse_o <= is_rd;
      wr_pulse_o <= is_wr;
      pre_pulse_o <= is_pre;
      ref_pulse_o <= is_ref;
      if (ck_rise) begin
        odt_on_o <= odt_s && odt_enabled && (pwr_q != PWR_SELF);
      end
      if (rd_step) begin
        rd_hold_q <= rd_data_i;
      end
      wr_beat_o <= wr_step;
      if (wr_step) begin
        // Beats are paced by the lower strobe alone
        wr_data_o <= {upper_data, dq_s[DQ_W/2-1:0]};
        wr_byte_en_o <= {upper_en, !lm_s};
      end
    end
  end
endmodule
`default_nettype wire

//--- ddr2_cmd_front_checker.sv
// Port-level assertions for the command front end
`default_nettype none
module ddr2_cmd_front_checker import ddr2_cmd_pkg::*; #(
  parameter int BANKS = 4,
  parameter int DQ_W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [BANK_W-1:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DQ_W-1:0] rd_data_i,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dq_oe_n_o,
  input wire logic strobe_oe_n_o,
  input wire logic [BANK_W-1:0] act_bank_o,
  input wire logic [ADDR_W-1:0] act_row_o,
  input wire logic act_pulse_o,
  input wire logic [COL_W-1:0] rw_col_o,
  input wire logic rd_pulse_o,
  input wire logic wr_pulse_o,
  input wire logic auto_pre_o,
  input wire logic pre_pulse_o,
  input wire logic [BANKS-1:0] pre_banks_o,
  input wire logic [ADDR_W-1:0] ext_mode_reg_o,
  input wire logic rd_beat_o,
  input wire logic odt_on_o,
  input wire logic clocks_on_o,
  input wire logic cmd_buf_on_o,
  input wire logic odt_buf_on_o,
  input wire logic [2:0] pwr_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Pins stand a whole link period, so a look-back of three cycles is exact
  a_act_decode: assert property (act_pulse_o |-> !$past(cs_n_i, 3)
    && !$past(ras_n_i, 3) && $past(cas_n_i, 3) && $past(we_n_i, 3)) else $error("bad decode");
  a_act_latch: assert property (act_pulse_o |-> act_bank_o == $past(ba_i, 3)
    && act_row_o == $past(addr_i, 3)) else $error("active address wrong");
  a_rw_column: assert property (rd_pulse_o || wr_pulse_o |->
    rw_col_o == $past(addr_i[COL_W-1:0], 3) && auto_pre_o == $past(addr_i[AP_BIT], 3))
    else $error("column or autoprecharge wrong");
  a_pre_mask: assert property (pre_pulse_o |-> pre_banks_o ==
    ($past(addr_i[AP_BIT], 3) ? {BANKS{1'b1}} : BANKS'(1) << $past(ba_i, 3)))
    else $error("precharge mask wrong");
  a_pd_gates: assert property ((pwr_state_o != 3'h0) [*2] |->
    !clocks_on_o && !cmd_buf_on_o) else $error("gates on in low power");
  a_on_gates: assert property ((pwr_state_o == 3'h0) [*2] |->
    clocks_on_o && cmd_buf_on_o && odt_buf_on_o) else $error("gates off while on");
  a_self_odt: assert property ((pwr_state_o == 3'h3) [*2] |-> !odt_buf_on_o)
    else $error("odt buffer on in self refresh");
  a_pd_refuse: assert property ((pwr_state_o != 3'h0) [*2] |->
    !(act_pulse_o || rd_pulse_o || wr_pulse_o || pre_pulse_o)) else $error("command in low power");
  a_odt_term: assert property (odt_on_o |->
    ext_mode_reg_o[EMR_ODT_LO_BIT] || ext_mode_reg_o[EMR_ODT_HI_BIT]) else $error("odt not enabled");
  a_rd_data: assert property (rd_beat_o |=> dq_o == $past(rd_data_i))
    else $error("read data not launched");
  a_strobe_dir: assert property (strobe_oe_n_o == dq_oe_n_o)
    else $error("strobe direction differs");
  c_act: cover property (act_pulse_o);
  c_beat: cover property (rd_beat_o && auto_pre_o);
  c_act_pd: cover property (pwr_state_o == 3'h2);
  c_self: cover property (pwr_state_o == 3'h3);
endmodule
bind ddr2_cmd_front ddr2_cmd_front_checker #(.BANKS(BANKS), .DQ_W(DQ_W)) u_chk (.*);
`default_nettype wire

//--- ddr2_ctrl_model.sv
// Controller-side model driving the command pins
`default_nettype none
module ddr2_ctrl_model (
  input wire logic clk_i,
  output logic ck_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic [2:0] cmd_o,
  output logic [1:0] ba_o,
  output logic [12:0] addr_o,
  output logic odt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Odd start keeps link edges off the system clock edges
  initial begin
    {ck_o, cke_o, odt_o, cs_n_o} = 4'h1;
    {cmd_o, ba_o, addr_o} = 18'h3ffff;
    #7;
    forever #200 ck_o = ~ck_o;
  end
  // Pins change after a falling crossing and hold through the rising one
  task automatic cmd(input logic cs, input logic [2:0] c, input logic [1:0] b,
                     input logic [12:0] a);
    @(negedge ck_o);
    @(negedge clk_i);
    {cs_n_o, cmd_o, ba_o, addr_o} = {cs, c, b, a};
    @(negedge ck_o);
    @(negedge clk_i);
    {cs_n_o, cmd_o, ba_o, addr_o} = {1'b0, 3'h7, ~b, ~a};
  endtask
  // Refresh registered with CKE falling enters self refresh when every bank is closed
  task automatic self_ref();
    @(negedge ck_o);
    @(negedge clk_i);
    {cke_o, cs_n_o, cmd_o} = {1'b0, 1'b0, 3'h1};
    @(negedge ck_o);
    @(negedge clk_i);
    cmd_o = 3'h7;
  endtask
  task automatic pin(input logic e, input logic o);
    @(negedge ck_o);
    @(negedge clk_i);
    {cke_o, odt_o} = {e, o};
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the command front end
`default_nettype none
module tb_top import ddr2_cmd_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rstn_i = 1'b0;
  logic ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i;
  logic [1:0] ba_i, wr_byte_en_o, act_bank_o, rw_bank_o;
  logic [12:0] addr_i, act_row_o, mode_reg_o, ext_mode_reg_o;
  logic [15:0] dq_i = 16'h0, rd_data_i = 16'h0, dq_o, wr_data_o;
  logic lower_byte_write_mask_i = 1'b0, upper_byte_write_mask_i = 1'b0;
  logic lower_byte_strobe_i = 1'b0, upper_byte_strobe_i = 1'b0;
  logic dq_oe_n_o, lower_byte_strobe_o, upper_byte_strobe_o, strobe_oe_n_o;
  logic act_pulse_o, rd_pulse_o, wr_pulse_o, auto_pre_o, pre_pulse_o, ref_pulse_o;
  logic rd_beat_o, wr_beat_o, odt_on_o, clocks_on_o, cmd_buf_on_o, odt_buf_on_o;
  logic [3:0] pre_banks_o, open_banks_o;
  logic [8:0] rw_col_o, beat_col_o;
  logic [2:0] pwr_state_o;
  logic [31:0] seed = 32'h8f78;
  logic [17:0] got;
  logic [17:0] expq[$];
  int errors = 0, checked = 0, beats = 0, refs = 0;
  ddr2_cmd_front dut (.*);
  ddr2_ctrl_model ctrl (.clk_i(clk_i), .ck_o(ck_i), .cke_o(cke_i), .cs_n_o(cs_n_i),
    .cmd_o({ras_n_i, cas_n_i, we_n_i}), .ba_o(ba_i), .addr_o(addr_i), .odt_o(odt_i));
  always #25 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Only commands the device should take leave a note behind
  task automatic send(input logic cs, input logic [2:0] c, input logic [1:0] b,
                      input logic [12:0] a);
    if (!cs && cke_i && c == CMD_ACT) expq.push_back({c, b, a});
    if (!cs && cke_i && (c == CMD_RD || c == CMD_WR))
      expq.push_back({c, b, 3'h0, a[AP_BIT], a[COL_W-1:0]});
    if (!cs && cke_i && c == CMD_PRE)
      expq.push_back({c, 11'h0, a[AP_BIT] ? 4'hf : 4'h1 << b});
    ctrl.cmd(cs, c, b, a);
  endtask
  always @(negedge clk_i) begin
    seed = xs(seed);
    rd_data_i <= seed[15:0];
  end
  always @(posedge clk_i) begin
    if (rd_beat_o) beats++;
    if (ref_pulse_o) refs++;
    if (wr_beat_o)
      chk({wr_byte_en_o, wr_data_o}, expq.size() ? expq.pop_front() : 18'h3ffff);
    if (act_pulse_o || rd_pulse_o || wr_pulse_o || pre_pulse_o) begin
      got = act_pulse_o ? {CMD_ACT, act_bank_o, act_row_o}
          : pre_pulse_o ? {CMD_PRE, 11'h0, pre_banks_o}
          : {rd_pulse_o ? CMD_RD : CMD_WR, rw_bank_o, 3'h0, auto_pre_o, rw_col_o};
      chk(got, expq.size() ? expq.pop_front() : 18'h3ffff);
    end
  end
  initial begin
    #300000;
    errors++;
    finish_test();
  end
  initial begin
    #100 rstn_i = 1'b1;
    chk({mode_reg_o, dq_oe_n_o, clocks_on_o}, {MR_RESET, 2'h3});
    ctrl.pin(1'b1, 1'b0);
    send(1'b0, CMD_NOP, 2'h0, 13'h0);
    send(1'b0, CMD_MRS, MRS_EXT1, 13'h0004);
    send(1'b0, CMD_MRS, MRS_BASE, 13'h000b);
    ctrl.pin(1'b1, 1'b1);
    send(1'b0, CMD_NOP, 2'h0, 13'h0);
    chk({mode_reg_o, ext_mode_reg_o, odt_on_o}, {13'h000b, 13'h0004, 1'b1});
    ctrl.pin(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      send(1'b0, CMD_ACT, i[1:0], seed[12:0]);
    end
    send(1'b1, CMD_PRE, 2'h1, 13'h0400);
    chk(open_banks_o, 4'hf);
    // Burst of eight, both crossings, second one closes its bank
    for (int i = 2; i < 4; i++) begin
      beats = 0;
      seed = xs(seed);
      send(1'b0, CMD_RD, i[1:0], {2'h0, i[0], 1'b0, seed[8:0]});
      repeat (60) @(posedge clk_i);
      chk(beats, 8);
    end
    chk(open_banks_o, 4'h7);
    send(1'b0, CMD_PRE, 2'h1, 13'h0);
    send(1'b0, CMD_NOP, 2'h0, 13'h0);
    chk(open_banks_o, 4'h5);
    send(1'b0, CMD_PRE, 2'h0, 13'h0400);
    send(1'b0, CMD_NOP, 2'h0, 13'h0);
    chk(open_banks_o, 4'h0);
    ctrl.pin(1'b0, 1'b0);
    send(1'b0, CMD_ACT, 2'h1, 13'h0);
    chk({pwr_state_o, clocks_on_o, cmd_buf_on_o, odt_buf_on_o}, {3'h1, 3'h1});
    ctrl.pin(1'b1, 1'b0);
    send(1'b0, CMD_NOP, 2'h0, 13'h0);
    send(1'b0, CMD_ACT, 2'h0, 13'h0123);
    ctrl.pin(1'b0, 1'b0);
    send(1'b0, CMD_NOP, 2'h0, 13'h0);
    chk(pwr_state_o, 3'h2);
    ctrl.pin(1'b1, 1'b0);
    send(1'b0, CMD_NOP, 2'h0, 13'h0);
    send(1'b0, CMD_WR, 2'h0, 13'h0005);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      seed = xs(seed);
      expq.push_back({~seed[17:16], seed[15:0]});
      {upper_byte_write_mask_i, lower_byte_write_mask_i, dq_i} = seed[17:0];
      {lower_byte_strobe_i, upper_byte_strobe_i} = {2{~lower_byte_strobe_i}};
      repeat (4) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    chk(beat_col_o, 9'h005);
    send(1'b0, CMD_PRE, 2'h0, 13'h0400);
    send(1'b0, CMD_REF, 2'h0, 13'h0);
    ctrl.self_ref();
    chk({pwr_state_o, odt_buf_on_o, clocks_on_o}, {3'h3, 2'h0});
    ctrl.pin(1'b1, 1'b0);
    repeat (4) @(posedge clk_i);
    chk(pwr_state_o, 3'h0);
    chk(refs, 1);
    repeat (20) @(posedge clk_i);
    chk(expq.size(), 0);
    finish_test();
  end
endmodule
`default_nettype wire
